// >>> hdl/gpo_map.svh
/*
 Register offsets, field positions, reset values and timing constants of the
 global power-ok block. Assumes inclusion by the package and the design files.
*/
`ifndef GPO_MAP_SVH
`define GPO_MAP_SVH

`define GPO_NCH            6
`define GPO_ADDR_W         4
`define GPO_DATA_W         32

// Byte offsets on the register bus.
`define GPO_OFF_CTRL       4'h0
`define GPO_OFF_IGNORE     4'h4
`define GPO_OFF_STATUS     4'h8
`define GPO_OFF_IRQ_STAT   4'hC

// Control register fields.
`define GPO_CTRL_ENA_LSB   0
`define GPO_CTRL_DIS_LSB   8
`define GPO_CTRL_MASK_LSB  24
`define GPO_CTRL_RST       32'h0000_0000
`define GPO_IGNORE_RST     32'h0000_0000

// Status register fields.
`define GPO_ST_OK_BIT      0
`define GPO_ST_RUN_BIT     1
`define GPO_ST_SEL_BIT     2
`define GPO_ST_THERM_BIT   3
`define GPO_ST_CH_LSB      8
`define GPO_ST_DIS_LSB     16

// Interrupt status and mask fields; the mask register shares the offset table.
`define GPO_OFF_IRQ_MASK   4'h0
`define GPO_IRQ_FALL_BIT   0
`define GPO_IRQ_RISE_BIT   1
`define GPO_IRQ_UV_BIT     2
`define GPO_IRQ_W          3

// Deglitch time and its count at 250 MHz.
`define GPO_CLK_MHZ        250
`define GPO_DEGLITCH_US    50
`define GPO_DEGLITCH_CYC   (`GPO_DEGLITCH_US * `GPO_CLK_MHZ)
`define GPO_CNT_W          14
`define GPO_ONE            14'h0001
`define GPO_ZERO           14'h0000

`endif

// >>> hdl/gpo_pkg.sv
/*
 Types of the global power-ok block. Assumes gpo_map.svh for all figures.
*/
`include "gpo_map.svh"

package gpo_pkg;

   typedef enum logic [1:0]
   {
      GPO_OFF  = 2'b00,
      GPO_RUN  = 2'b01
   } gpo_run_e;

   typedef struct packed
   {
      logic [`GPO_NCH-1:0] enable;
      logic [`GPO_NCH-1:0] discharge;
   } gpo_ctrl_s;

   typedef struct packed
   {
      logic                 uv_above_upper;
      logic                 uv_below_lower;
      logic                 thermal_fault;
      logic                 threshold_select_pin;
      logic [`GPO_NCH-1:0]  ch_power_ok;
   } gpo_pins_s;

   typedef logic [`GPO_IRQ_W-1:0] gpo_irq_t;

endpackage

// >>> hdl/gpo_sync.sv
/*
 Two-flop synchroniser for a vector of asynchronous levels.
 Assumes the caller reads only the output.
*/
`timescale 1ns/1ps
`include "gpo_map.svh"

module gpo_sync #(
   parameter int W = 1
)
(
   // Clock and reset.
   input  wire logic         i_sys_clk,
   input  wire logic         i_resetn,
   // Levels.
   input  wire logic [W-1:0] i_async,
   output      logic [W-1:0] o_sync
);

   logic [W-1:0] stage1;

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         stage1 <= '0;
         o_sync <= '0;
      end
      else
      begin
         stage1 <= i_async;
         o_sync <= stage1;
      end
   end

endmodule // gpo_sync

// >>> hdl/gpo_global_power_ok.sv
/*
 Global power-ok logic: combines channel power-ok flags and the thermal fault
 into an open-drain output with falling-edge deglitch, per-channel ignore,
 supply start/hold, threshold selection and discharge gating, plus a classic
 Wishbone slave. Assumes all pin inputs are asynchronous to i_sys_clk.
*/
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
// Behaviour
// - Global power-ok released high only while all unignored channel flags are asserted.
// - Output driven low on any unignored channel fault or thermal fault.
// - Falling transitions are deglitched; fault must persist 50 us first.
// - Per-channel ignore setting removes that channel from the combination.
// - Threshold-select pin high picks upper reset levels, low picks lower.
// - Discharge path on only for a disabled channel with discharge enabled.
// - Start-up begins when supply rises above upper comparator threshold.
// - Outputs stay enabled until supply falls below the lower threshold.
`timescale 1ns/1ps
`include "gpo_map.svh"

module gpo_global_power_ok
(
   // Clock and reset.
   input  wire logic                 i_sys_clk,
   input  wire logic                 i_resetn,
   // Wishbone slave.
   input  wire logic                 i_wb_cyc,
   input  wire logic                 i_wb_stb,
   input  wire logic                 i_wb_we,
   input  wire logic [`GPO_ADDR_W-1:0] i_wb_adr,
   input  wire logic [3:0]           i_wb_sel,
   input  wire logic [`GPO_DATA_W-1:0] i_wb_dat,
   output      logic [`GPO_DATA_W-1:0] o_wb_dat,
   output      logic                 o_wb_ack,
   // Analog and strap inputs.
   input  wire gpo_pkg::gpo_pins_s   i_pins,
   // Open-drain global power-ok pin.
   input  wire logic                 i_global_power_ok,
   output      logic                 o_global_power_ok,
   output      logic                 o_global_power_ok_oe,
   // Sequencer outputs.
   output      logic                 o_outputs_run,
   output      logic [`GPO_NCH-1:0]  o_output_discharge_enable,
   output      logic                 o_rising_reset_level,
   output      logic                 o_falling_reset_level,
   // Interrupt.
   output      logic                 o_irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Synchronised inputs.

   gpo_pkg::gpo_pins_s pins;
   logic               pin_level_sync;
   logic               pin_level_sync_q;

   gpo_sync #(.W($bits(gpo_pkg::gpo_pins_s))) u_sync_pins
   (
      .i_sys_clk (i_sys_clk),
      .i_resetn  (i_resetn),
      .i_async   (i_pins),
      .o_sync    (pins)
   );

   gpo_sync #(.W(1)) u_sync_pin
   (
      .i_sys_clk (i_sys_clk),
      .i_resetn  (i_resetn),
      .i_async   (i_global_power_ok),
      .o_sync    (pin_level_sync)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Registers.

   gpo_pkg::gpo_ctrl_s  ctrl;
   logic [`GPO_NCH-1:0] power_ok_fault_ignore;
   gpo_pkg::gpo_irq_t   irq_stat;
   gpo_pkg::gpo_irq_t   irq_mask;
   logic                wr_en;
   logic                rd_en;
   gpo_pkg::gpo_irq_t   irq_set;
   gpo_pkg::gpo_irq_t   irq_clr;

   // A single mapped window; the mask lives behind the control word's top bits.
   // Writes land on the edge where the master sees ack, so a held request stores once.
   assign wr_en = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack;
   assign rd_en = i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack;

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         ctrl     <= gpo_pkg::gpo_ctrl_s'(`GPO_CTRL_RST);
         irq_mask <= '0;
      end
      else if (wr_en && i_wb_adr == `GPO_OFF_CTRL)
      begin
         if (i_wb_sel[0])
         begin
            ctrl.enable <= i_wb_dat[`GPO_CTRL_ENA_LSB +: `GPO_NCH];
         end
         if (i_wb_sel[1])
         begin
            ctrl.discharge <= i_wb_dat[`GPO_CTRL_DIS_LSB +: `GPO_NCH];
         end
         if (i_wb_sel[3])
         begin
            irq_mask <= i_wb_dat[`GPO_CTRL_MASK_LSB +: `GPO_IRQ_W];
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         power_ok_fault_ignore <= `GPO_NCH'(`GPO_IGNORE_RST);
      end
      else if (wr_en && i_wb_adr == `GPO_OFF_IGNORE && i_wb_sel[0])
      begin
         power_ok_fault_ignore <= i_wb_dat[`GPO_NCH-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Supply start and hold.

   gpo_pkg::gpo_run_e run_state;

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         run_state <= gpo_pkg::GPO_OFF;
      end
      else
      begin
         unique case (run_state)
            gpo_pkg::GPO_OFF:
            begin
               if (pins.uv_above_upper)
               begin
                  run_state <= gpo_pkg::GPO_RUN;
               end
            end
            gpo_pkg::GPO_RUN:
            begin
               if (pins.uv_below_lower)
               begin
                  run_state <= gpo_pkg::GPO_OFF;
               end
            end
            default:
            begin
               run_state <= gpo_pkg::GPO_OFF;
            end
         endcase
      end
   end

   assign o_outputs_run = (run_state == gpo_pkg::GPO_RUN);

   ////////////////////////////////////////////////////////////////////////////
   // Reset level selection and discharge gating.

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_rising_reset_level  <= 1'b0;
         o_falling_reset_level <= 1'b0;
      end
      else
      begin
         o_rising_reset_level  <= pins.threshold_select_pin;
         o_falling_reset_level <= pins.threshold_select_pin;
      end
   end

   // A channel counts as disabled when its enable is off or the supply is down.
   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_output_discharge_enable <= '0;
      end
      else
      begin
         o_output_discharge_enable <= ~(ctrl.enable & {`GPO_NCH{o_outputs_run}})
                                      & ctrl.discharge;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power-ok combination and deglitch.

   logic                  all_ok;
   logic                  fault;
   logic [`GPO_CNT_W-1:0] glitch_cnt;
   logic                  power_ok;

   // Ignored channels count as good, so they can never pull the output down.
   assign all_ok = &(pins.ch_power_ok | power_ok_fault_ignore);
   assign fault  = !all_ok || pins.thermal_fault;

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         glitch_cnt <= `GPO_ZERO;
         power_ok   <= 1'b0;
      end
      else if (!fault)
      begin
         glitch_cnt <= `GPO_ZERO;
         power_ok   <= 1'b1;
      end
      else if (power_ok)
      begin
         // A fault shorter than the window leaves the output high.
         if (glitch_cnt == `GPO_CNT_W'(`GPO_DEGLITCH_CYC - 1))
         begin
            power_ok   <= 1'b0;
            glitch_cnt <= `GPO_ZERO;
         end
         else
         begin
            glitch_cnt <= glitch_cnt + `GPO_ONE;
         end
      end
   end

   // Open drain: drive low when not ok, release otherwise.
   assign o_global_power_ok    = 1'b0;
   assign o_global_power_ok_oe = !power_ok;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts.

   logic power_ok_q;
   logic run_q;

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         power_ok_q       <= 1'b0;
         run_q            <= 1'b0;
         pin_level_sync_q <= 1'b0;
      end
      else
      begin
         power_ok_q       <= power_ok;
         run_q            <= o_outputs_run;
         pin_level_sync_q <= pin_level_sync;
      end
   end

   always_comb
   begin
      irq_set = '0;
      irq_set[`GPO_IRQ_FALL_BIT] = power_ok_q && !power_ok;
      irq_set[`GPO_IRQ_RISE_BIT] = !power_ok_q && power_ok;
      irq_set[`GPO_IRQ_UV_BIT]   = run_q && !o_outputs_run;
      irq_clr = '0;
      if (wr_en && i_wb_adr == `GPO_OFF_IRQ_STAT && i_wb_sel[0])
      begin
         irq_clr = i_wb_dat[`GPO_IRQ_W-1:0];
      end
   end

   // Set wins over a same-cycle write-one clear.
   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         irq_stat <= '0;
      end
      else
      begin
         irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      end
   end

   assign o_irq = |(irq_stat & irq_mask);

   ////////////////////////////////////////////////////////////////////////////
   // Read path. Unmapped offsets read zero and still acknowledge.

   logic [`GPO_DATA_W-1:0] rd_word;

   always_comb
   begin
      rd_word = '0;
      unique case (i_wb_adr)
         `GPO_OFF_CTRL:
         begin
            rd_word[`GPO_CTRL_ENA_LSB +: `GPO_NCH] = ctrl.enable;
            rd_word[`GPO_CTRL_DIS_LSB +: `GPO_NCH] = ctrl.discharge;
            rd_word[`GPO_CTRL_MASK_LSB +: `GPO_IRQ_W] = irq_mask;
         end
         `GPO_OFF_IGNORE:
         begin
            rd_word[`GPO_NCH-1:0] = power_ok_fault_ignore;
         end
         `GPO_OFF_STATUS:
         begin
            rd_word[`GPO_ST_OK_BIT]    = pin_level_sync_q;
            rd_word[`GPO_ST_RUN_BIT]   = o_outputs_run;
            rd_word[`GPO_ST_SEL_BIT]   = pins.threshold_select_pin;
            rd_word[`GPO_ST_THERM_BIT] = pins.thermal_fault;
            rd_word[`GPO_ST_CH_LSB +: `GPO_NCH]  = pins.ch_power_ok;
            rd_word[`GPO_ST_DIS_LSB +: `GPO_NCH] = o_output_discharge_enable;
         end
         `GPO_OFF_IRQ_STAT:
         begin
            rd_word[`GPO_IRQ_W-1:0] = irq_stat;
         end
         default:
         begin
            rd_word = '0;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= '0;
      end
      else
      begin
         o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
         o_wb_dat <= rd_en ? rd_word : '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions.

   a_release_all_ok: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      $rose(power_ok) |-> $past(!fault))
      else $error("Power-ok released while a fault was present.");

   a_fault_drives_low: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      power_ok && fault && glitch_cnt == `GPO_CNT_W'(`GPO_DEGLITCH_CYC - 1)
      |=> o_global_power_ok_oe && !o_global_power_ok)
      else $error("Pin not driven low after a persisting fault.");

   a_deglitch_hold: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      $fell(power_ok) |-> glitch_cnt == `GPO_ZERO && $past(fault))
      else $error("Power-ok fell without a persisting fault.");

   a_deglitch_short: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      power_ok && fault && glitch_cnt < `GPO_CNT_W'(`GPO_DEGLITCH_CYC - 1) |=> power_ok)
      else $error("Power-ok fell before the deglitch interval.");

   a_ignore_mask: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      !pins.thermal_fault && (~pins.ch_power_ok & ~power_ok_fault_ignore) == '0 |=> power_ok)
      else $error("Ignored channel still produced a fault.");

   a_level_select: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      ##1 o_rising_reset_level == $past(pins.threshold_select_pin)
      && o_falling_reset_level == o_rising_reset_level)
      else $error("Reset level does not follow the select pin.");

   a_discharge_gate: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      ##1 (o_output_discharge_enable & $past(ctrl.enable) & {`GPO_NCH{$past(o_outputs_run)}})
      == '0)
      else $error("Discharge on for an enabled channel.");

   a_start_up: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      !o_outputs_run && pins.uv_above_upper |=> o_outputs_run)
      else $error("Start-up did not begin on supply rise.");

   a_hold_run: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      o_outputs_run && !pins.uv_below_lower |=> o_outputs_run)
      else $error("Outputs dropped without supply falling below lower level.");

   a_counter_restart: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      !fault |=> glitch_cnt == `GPO_ZERO)
      else $error("Deglitch counter did not restart when fault cleared.");

endmodule // gpo_global_power_ok

// >>> verif/gpo_host_model.sv
/*
 Host side of the open-drain global power-ok wire.
 Assumes the host holds the pull-up resistor on that wire.
*/
`timescale 1ns/1ps

module gpo_host_model
(
   // Device side of the pin.
   input  wire logic i_pin_data,
   input  wire logic i_pin_oe,
   // Resolved wire level.
   output      logic o_wire_level
);
   // The pull-up wins whenever the device lets go of the pin.
   assign o_wire_level = i_pin_oe ? i_pin_data : 1'b1;
endmodule // gpo_host_model

// >>> verif/gpo_global_power_ok_tb.sv
/*
 Self-checking bench: a row table for start, hold, strap and discharge, then
 hand tests of deglitch, ignore, thermal fault, interrupts and reset.
 Assumes the host model pulls the power-ok wire up.
*/
`timescale 1ns/1ps
`include "gpo_map.svh"

`define CHK(act, exp) \
   begin \
      cmp_count++; \
      if ((act) !== (exp)) \
      begin \
         num_errors++; \
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (act), (exp)); \
      end \
   end

module gpo_global_power_ok_tb;

   typedef struct packed
   {
      gpo_pkg::gpo_pins_s pins;
      logic [31:0]        ctrl;
      logic               run;
      logic               lvl;
      logic [5:0]         dis;
   } gpo_row_s;

   logic               sys_clk;
   logic               resetn;
   logic               cyc, stb, we;
   logic [3:0]         adr, sel;
   logic [31:0]        wdat, rdat;
   logic               ack, irq, run, rlvl, flvl;
   logic               pin_data, pin_oe, pin_level, oe_seen;
   logic [5:0]         dis;
   gpo_pkg::gpo_pins_s pins;
   int                 num_errors, cmp_count, cycles;

   // Row order matters: the run state carries from one row to the next.
   gpo_row_s rows [5] = '{
      '{10'h27F, 32'h0000_3F3F, 1'h1, 1'h1, 6'h00},
      '{10'h03F, 32'h0000_3F0F, 1'h1, 1'h0, 6'h30},
      '{10'h13F, 32'h0000_3F0F, 1'h0, 1'h0, 6'h3F},
      '{10'h03F, 32'h0000_053F, 1'h0, 1'h0, 6'h05},
      '{10'h27F, 32'h0000_053F, 1'h1, 1'h1, 6'h00}};

   gpo_global_power_ok u_gpo_global_power_ok
   (
      .i_sys_clk                 (sys_clk),
      .i_resetn                  (resetn),
      .i_wb_cyc                  (cyc),
      .i_wb_stb                  (stb),
      .i_wb_we                   (we),
      .i_wb_adr                  (adr),
      .i_wb_sel                  (sel),
      .i_wb_dat                  (wdat),
      .o_wb_dat                  (rdat),
      .o_wb_ack                  (ack),
      .i_pins                    (pins),
      .i_global_power_ok         (pin_level),
      .o_global_power_ok         (pin_data),
      .o_global_power_ok_oe      (pin_oe),
      .o_outputs_run             (run),
      .o_output_discharge_enable (dis),
      .o_rising_reset_level      (rlvl),
      .o_falling_reset_level     (flvl),
      .o_irq                     (irq)
   );

   gpo_host_model u_gpo_host_model
   (
      .i_pin_data   (pin_data),
      .i_pin_oe     (pin_oe),
      .o_wire_level (pin_level)
   );

   ////////////////////////////////////////////////////////////////////////////
   always #2 sys_clk = ~sys_clk;

   // A short pulse on the pin would be missed by end-of-wait sampling alone.
   always @(posedge sys_clk)
   begin
      cycles++;
      if (pin_oe === 1'b1)
         oe_seen = 1'b1;
      if (cycles == 60000)
      begin
         num_errors++;
         complete_run();
      end
   end

   task automatic complete_run();
      if (num_errors == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] r);
      @(posedge sys_clk);
      {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
      // Only the bench timeout ends a wait for the acknowledge.
      do
      begin
         @(posedge sys_clk);
      end
      while (ack !== 1'b1);
      r = rdat;
      {cyc, stb, we} <= 3'b000;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, 4'hF, d, r);
   endtask

   task automatic rdc(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 4'hF, 32'h0000_0000, r);
      `CHK(r, e)
   endtask

   task automatic setp(input gpo_pkg::gpo_pins_s v);
      @(posedge sys_clk);
      pins <= v;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [31:0] r;
      sys_clk = 1'b0;
      resetn = 1'b0;
      {cyc, stb, we, adr, sel, wdat} = '0;
      pins = 10'h03F;
      oe_seen = 1'b0;
      num_errors = 0;
      cmp_count = 0;
      cycles = 0;
      wt(10);
      `CHK({pin_oe, run, dis, rlvl, flvl, irq, ack}, 12'h800)
      wt(6);
      resetn <= 1'b1;
      wt(8);
      `CHK(pin_level, 1'b1)
      rdc(4'h0, 32'h0000_0000);
      rdc(4'h4, 32'h0000_0000);
      rdc(4'h2, 32'h0000_0000);
      foreach (rows[i])
      begin
         wr(4'h0, rows[i].ctrl);
         setp(rows[i].pins);
         wt(8);
         `CHK(run, rows[i].run)
         `CHK({rlvl, flvl}, {2{rows[i].lvl}})
         `CHK(dis, rows[i].dis)
      end
      wr(4'hC, 32'h0000_0007);
      rdc(4'hC, 32'h0000_0000);
      setp(10'h17F);
      wt(8);
      rdc(4'hC, 32'h0000_0004);
      `CHK(irq, 1'b0)
      wr(4'h0, 32'h0400_053F);
      wt(1);
      `CHK(irq, 1'b1)
      wr(4'hC, 32'h0000_0004);
      wt(1);
      `CHK(irq, 1'b0)
      setp(10'h27F);
      wt(8);
      `CHK(run, 1'b1)
      bus(1'b1, 4'h0, 4'h1, 32'hFFFF_FF00, r);
      rdc(4'h0, 32'h0400_0500);
      wr(4'h0, 32'h0700_053F);
      // A fault shorter than the deglitch time, then a fresh one.
      setp(10'h27B);
      oe_seen = 1'b0;
      wt(12000);
      setp(10'h27F);
      wt(20);
      `CHK(oe_seen, 1'b0)
      setp(10'h27B);
      wt(12400);
      `CHK(oe_seen, 1'b0)
      wt(200);
      `CHK({pin_oe, pin_level, irq}, 3'b101)
      rdc(4'h8, 32'h0000_3B06);
      rdc(4'hC, 32'h0000_0001);
      setp(10'h27F);
      wt(6);
      `CHK({pin_oe, pin_level}, 2'b01)
      rdc(4'hC, 32'h0000_0003);
      wr(4'hC, 32'h0000_0003);
      rdc(4'hC, 32'h0000_0000);
      wr(4'h4, 32'h0000_0004);
      rdc(4'h4, 32'h0000_0004);
      setp(10'h27B);
      oe_seen = 1'b0;
      wt(12600);
      `CHK(oe_seen, 1'b0)
      setp(10'h2FB);
      wt(12600);
      `CHK({pin_oe, pin_level}, 2'b10)
      rdc(4'h8, 32'h0000_3B0E);
      resetn <= 1'b0;
      wt(3);
      `CHK({pin_oe, run, dis}, 8'h80)
      resetn <= 1'b1;
      setp(10'h27F);
      wt(8);
      rdc(4'h4, 32'h0000_0000);
      `CHK(pin_level, 1'b1)
      complete_run();
   end

endmodule // gpo_global_power_ok_tb
